// >>> logic/volume_ramp_automute_ctrl.sv
// Emergency ramp, auto mute and output-stage control registers
// ==========================================================
module volume_ramp_automute_ctrl #(
    parameter int SAMPLE_W = 24
) (
    input wire logic clk_sys_i,
    input wire logic sys_rst_i,
    input wire vramp_pkg::reg_req_t reg_req_i,
    output logic [7:0] reg_rdata_o,
    input wire vramp_pkg::audio_in_t audio_i,
    input wire logic [7:0] digital_volume_level_i,
    input wire logic [7:0] normal_ramp_cfg_i,
    input wire logic clock_fault_i,
    input wire logic supply_loss_i,
    output logic [7:0] left_volume_o,
    output logic [7:0] right_volume_o,
    output logic left_auto_mute_o,
    output logic right_auto_mute_o,
    output logic emergency_active_o,
    output logic [1:0] loop_bandwidth_o,
    output logic pwm_in_phase_o,
    output logic [4:0] output_attenuation_o
);
    import vramp_pkg::*;

    if (SAMPLE_W != 24) begin : g_bad_width
        $error("volume_ramp_automute_ctrl: carrier holds 24-bit samples");
    end

    // ==========================================================
    // Register file
    logic [7:0] emergency_ramp_config;
    logic [7:0] zero_mute_enable;
    logic [7:0] zero_mute_hold_time;
    logic [7:0] output_stage_config;
    logic [7:0] output_gain_trim;

    wire logic wr_emerg = reg_req_i.wr && reg_req_i.addr == EMERG_RAMP_OFS;
    wire logic wr_mute = reg_req_i.wr && reg_req_i.addr == MUTE_EN_OFS;
    wire logic wr_hold = reg_req_i.wr && reg_req_i.addr == HOLD_TIME_OFS;
    wire logic wr_stage = reg_req_i.wr && reg_req_i.addr == STAGE_CFG_OFS;
    wire logic wr_gain = reg_req_i.wr && reg_req_i.addr == GAIN_TRIM_OFS;

    // Reserved bits are kept as plain storage and drive nothing
    always_ff @(posedge clk_sys_i) begin
        if (sys_rst_i) begin
            emergency_ramp_config <= EMERG_RAMP_RST;
            zero_mute_enable <= MUTE_EN_RST;
            zero_mute_hold_time <= HOLD_TIME_RST;
            output_stage_config <= STAGE_CFG_RST;
            output_gain_trim <= GAIN_TRIM_RST;
        end else begin
            if (wr_emerg) emergency_ramp_config <= reg_req_i.wdata;
            if (wr_mute) zero_mute_enable <= reg_req_i.wdata;
            if (wr_hold) zero_mute_hold_time <= reg_req_i.wdata;
            if (wr_stage) output_stage_config <= reg_req_i.wdata;
            if (wr_gain) output_gain_trim <= reg_req_i.wdata;
        end
    end

    // Bandwidth choice per switching frequency is left to software
    assign loop_bandwidth_o = output_stage_config[BW_HI:BW_LO];
    assign pwm_in_phase_o = output_stage_config[PHASE_BIT];
    assign output_attenuation_o =
        output_gain_trim[ATTEN_HI:ATTEN_LO];

    // ==========================================================
    // Read-back; unmapped offsets read zero
    wire logic [7:0] status_word = {5'h00, emergency_active_o,
        right_auto_mute_o, left_auto_mute_o};
    logic [7:0] read_mux;
    always_comb begin
        case (reg_req_i.addr)
            EMERG_RAMP_OFS: read_mux = emergency_ramp_config;
            MUTE_EN_OFS: read_mux = zero_mute_enable;
            HOLD_TIME_OFS: read_mux = zero_mute_hold_time;
            STATUS_OFS: read_mux = status_word;
            STAGE_CFG_OFS: read_mux = output_stage_config;
            GAIN_TRIM_OFS: read_mux = output_gain_trim;
            default: read_mux = 8'h00;
        endcase
    end

    always_ff @(posedge clk_sys_i) begin
        if (sys_rst_i) reg_rdata_o <= 8'h00;
        else reg_rdata_o <= read_mux;
    end

    // ==========================================================
    // Fault pins: three flops, change taken once the last two agree
    logic [2:0] fault_sync;
    logic [2:0] loss_sync;
    always_ff @(posedge clk_sys_i) begin
        if (sys_rst_i) begin
            fault_sync <= 3'h0;
            loss_sync <= 3'h0;
        end else begin
            fault_sync <= {fault_sync[1:0], clock_fault_i};
            loss_sync <= {loss_sync[1:0], supply_loss_i};
        end
    end

    logic fault_level;
    logic loss_level;
    always_ff @(posedge clk_sys_i) begin
        if (sys_rst_i) begin
            fault_level <= 1'b0;
            loss_level <= 1'b0;
        end else begin
            if (fault_sync[1] == fault_sync[2]) fault_level <= fault_sync[2];
            if (loss_sync[1] == loss_sync[2]) loss_level <= loss_sync[2];
        end
    end

    wire logic emergency = fault_level || loss_level;
    always_ff @(posedge clk_sys_i) begin
        if (sys_rst_i) emergency_active_o <= 1'b0;
        else emergency_active_o <= emergency;
    end

    // ==========================================================
    // Zero-run detection and mute decision
    logic left_qualify;
    logic right_qualify;

    zero_run_detect #(.SAMPLE_W(SAMPLE_W)) u_left_zero (
        .clk_sys_i(clk_sys_i),
        .sys_rst_i(sys_rst_i),
        .sample_valid_i(audio_i.valid),
        .sample_i(audio_i.left),
        .hold_code_i(zero_mute_hold_time[LEFT_HOLD_HI:LEFT_HOLD_LO]),
        .qualify_o(left_qualify)
    );

    zero_run_detect #(.SAMPLE_W(SAMPLE_W)) u_right_zero (
        .clk_sys_i(clk_sys_i),
        .sys_rst_i(sys_rst_i),
        .sample_valid_i(audio_i.valid),
        .sample_i(audio_i.right),
        .hold_code_i(zero_mute_hold_time[RIGHT_HOLD_HI:RIGHT_HOLD_LO]),
        .qualify_o(right_qualify)
    );

    wire logic left_en = zero_mute_enable[MUTE_LEFT_BIT];
    wire logic right_en = zero_mute_enable[MUTE_RIGHT_BIT];
    wire logic joint = zero_mute_enable[MUTE_JOINT_BIT];
    wire logic left_ready = left_en && left_qualify;
    wire logic right_ready = right_en && right_qualify;
    wire logic both_ready = left_ready && right_ready;
    wire logic next_left_mute = joint ? both_ready : left_ready;
    wire logic next_right_mute = joint ? both_ready : right_ready;

    always_ff @(posedge clk_sys_i) begin
        if (sys_rst_i) begin
            left_auto_mute_o <= 1'b0;
            right_auto_mute_o <= 1'b0;
        end else begin
            left_auto_mute_o <= next_left_mute;
            right_auto_mute_o <= next_right_mute;
        end
    end

    // ==========================================================
    // Volume ramp engine, one per channel
    // Higher code is quieter; one code is 0.5 dB
    function automatic logic [7:0] step_toward(input logic [7:0] cur,
        input logic [7:0] tgt, input logic [1:0] step_code);
        logic [8:0] delta;
        logic [8:0] sum;
        delta = {1'b0, STEP_4DB >> step_code};
        sum = 9'h000;
        if (cur < tgt) begin
            sum = {1'b0, cur} + delta;
            return (sum > {1'b0, tgt}) ? tgt : sum[7:0];
        end else if (cur > tgt) begin
            sum = {1'b0, cur} - delta;
            return (sum[8] || sum[7:0] < tgt) ? tgt : sum[7:0];
        end
        return cur;
    endfunction

    // One update per 1, 2 or 4 samples
    logic [1:0] fs_phase;
    function automatic logic rate_due(input logic [1:0] rate,
        input logic [1:0] phase);
        case (rate)
            RATE_EVERY1: return 1'b1;
            RATE_EVERY2: return phase[0] == 1'b0;
            default: return phase == 2'h0;
        endcase
    endfunction

    always_ff @(posedge clk_sys_i) begin
        if (sys_rst_i) fs_phase <= 2'h0;
        else if (audio_i.valid) fs_phase <= fs_phase + 2'h1;
    end

    wire logic [1:0] fast_rate = emergency_ramp_config[RATE_HI:RATE_LO];
    wire logic [1:0] fast_step = emergency_ramp_config[STEP_HI:STEP_LO];
    logic [7:0] vol [2];
    logic [7:0] next_vol [2];
    wire logic [1:0] chan_mute = {right_auto_mute_o, left_auto_mute_o};

    for (genvar c = 0; c < 2; c++) begin : g_chan
        // Muting on fault or silence drives toward the mute code
        wire logic [7:0] target = (emergency || chan_mute[c]) ?
            VOL_MUTE : digital_volume_level_i;
        wire logic going_down = target > vol[c];
        wire logic [1:0] rate = emergency ? fast_rate : going_down ?
            normal_ramp_cfg_i[RATE_HI:RATE_LO] :
            normal_ramp_cfg_i[UP_RATE_HI:UP_RATE_LO];
        wire logic [1:0] step = emergency ? fast_step : going_down ?
            normal_ramp_cfg_i[STEP_HI:STEP_LO] :
            normal_ramp_cfg_i[UP_STEP_HI:UP_STEP_LO];
        wire logic tick = audio_i.valid && rate_due(rate, fs_phase);
        assign next_vol[c] = (rate == RATE_INSTANT) ? target :
            tick ? step_toward(vol[c], target, step) : vol[c];

        always_ff @(posedge clk_sys_i) begin
            if (sys_rst_i) vol[c] <= VOL_UNITY;
            else vol[c] <= next_vol[c];
        end
    end

    assign left_volume_o = vol[0];
    assign right_volume_o = vol[1];

    // ==========================================================
    // Assertions
    a_instant_mute: assert property (@(posedge clk_sys_i)
        disable iff (sys_rst_i)
        emergency && fast_rate == RATE_INSTANT
        |=> left_volume_o == VOL_MUTE && right_volume_o == VOL_MUTE)
        else $error("instant emergency mute did not reach mute code");

    a_fast_step: assert property (@(posedge clk_sys_i)
        disable iff (sys_rst_i)
        emergency && fast_rate == RATE_EVERY1 && fast_step == 2'h0 &&
        audio_i.valid && left_volume_o < 8'hf7
        |=> left_volume_o == $past(left_volume_o) + 8'h08)
        else $error("emergency 4 dB step not applied");

    a_rate_hold: assert property (@(posedge clk_sys_i)
        disable iff (sys_rst_i)
        emergency && fast_rate != RATE_INSTANT && !audio_i.valid
        |=> $stable(left_volume_o) && $stable(right_volume_o))
        else $error("volume moved between sample periods");

    a_left_enable: assert property (@(posedge clk_sys_i)
        disable iff (sys_rst_i)
        !zero_mute_enable[MUTE_LEFT_BIT] |=> !left_auto_mute_o)
        else $error("left muted while its enable is clear");

    a_right_enable: assert property (@(posedge clk_sys_i)
        disable iff (sys_rst_i)
        !zero_mute_enable[MUTE_RIGHT_BIT] |=> !right_auto_mute_o)
        else $error("right muted while its enable is clear");

    a_joint_mute: assert property (@(posedge clk_sys_i)
        disable iff (sys_rst_i)
        joint && !(left_ready && right_ready)
        |=> !left_auto_mute_o && !right_auto_mute_o)
        else $error("joint mode muted with one channel active");

    a_mute_reset: assert property (@(posedge clk_sys_i)
        sys_rst_i |=> zero_mute_enable == 8'h07 &&
        emergency_ramp_config == 8'h30 && output_stage_config == 8'h00)
        else $error("register reset value wrong");

    a_write_readback: assert property (@(posedge clk_sys_i)
        disable iff (sys_rst_i)
        wr_mute ##1 reg_req_i.addr == MUTE_EN_OFS && !reg_req_i.wr
        |=> reg_rdata_o == $past(reg_req_i.wdata, 2))
        else $error("written value not read back");

    a_bw_field: assert property (@(posedge clk_sys_i)
        disable iff (sys_rst_i)
        wr_stage |=> loop_bandwidth_o == $past(reg_req_i.wdata[6:5]) &&
        pwm_in_phase_o == $past(reg_req_i.wdata[0]))
        else $error("stage configuration not applied");

    a_atten_field: assert property (@(posedge clk_sys_i)
        disable iff (sys_rst_i)
        wr_gain |=> output_attenuation_o == $past(reg_req_i.wdata[4:0]))
        else $error("attenuation setting not applied");

endmodule

// >>> logic/vramp_pkg.sv
// Shared constants, register map and carrier types of the volume/mute block
package vramp_pkg;

    // ==========================================================
    // Register offsets
    localparam logic [7:0] EMERG_RAMP_OFS = 8'h4f;
    localparam logic [7:0] MUTE_EN_OFS = 8'h50;
    localparam logic [7:0] HOLD_TIME_OFS = 8'h51;
    localparam logic [7:0] STATUS_OFS = 8'h52;
    localparam logic [7:0] STAGE_CFG_OFS = 8'h53;
    localparam logic [7:0] GAIN_TRIM_OFS = 8'h54;

    // ==========================================================
    // Reset values
    localparam logic [7:0] EMERG_RAMP_RST = 8'h30;
    localparam logic [7:0] MUTE_EN_RST = 8'h07;
    localparam logic [7:0] HOLD_TIME_RST = 8'h00;
    localparam logic [7:0] STAGE_CFG_RST = 8'h00;
    localparam logic [7:0] GAIN_TRIM_RST = 8'h00;

    // ==========================================================
    // Field positions
    localparam int RATE_HI = 7;
    localparam int RATE_LO = 6;
    localparam int STEP_HI = 5;
    localparam int STEP_LO = 4;
    localparam int UP_RATE_HI = 3;
    localparam int UP_RATE_LO = 2;
    localparam int UP_STEP_HI = 1;
    localparam int UP_STEP_LO = 0;
    localparam int MUTE_LEFT_BIT = 0;
    localparam int MUTE_RIGHT_BIT = 1;
    localparam int MUTE_JOINT_BIT = 2;
    localparam int LEFT_HOLD_HI = 6;
    localparam int LEFT_HOLD_LO = 4;
    localparam int RIGHT_HOLD_HI = 2;
    localparam int RIGHT_HOLD_LO = 0;
    localparam int BW_HI = 6;
    localparam int BW_LO = 5;
    localparam int PHASE_BIT = 0;
    localparam int ATTEN_HI = 4;
    localparam int ATTEN_LO = 0;

    // ==========================================================
    // Volume codes and ramp encodings
    localparam logic [7:0] VOL_MUTE = 8'hff;
    localparam logic [7:0] VOL_UNITY = 8'h30;
    localparam logic [1:0] RATE_EVERY1 = 2'h0;
    localparam logic [1:0] RATE_EVERY2 = 2'h1;
    localparam logic [1:0] RATE_INSTANT = 2'h3;
    localparam logic [7:0] STEP_4DB = 8'h08;

    // ==========================================================
    // Zero-run hold times, in microseconds at the reference rate
    localparam int FS_REF_KHZ = 96;
    localparam int HOLD_US_0 = 11500;
    localparam int HOLD_US_1 = 53000;
    localparam int HOLD_US_2 = 106500;
    localparam int HOLD_US_3 = 266500;
    localparam int HOLD_US_4 = 535000;
    localparam int HOLD_US_5 = 1065000;
    localparam int HOLD_US_6 = 2665000;
    localparam int HOLD_US_7 = 5330000;
    localparam int HOLD_W = 19;

    // ==========================================================
    // Carrier types
    typedef struct packed {
        logic valid;
        logic [23:0] left;
        logic [23:0] right;
    } audio_in_t;

    typedef struct packed {
        logic wr;
        logic [7:0] addr;
        logic [7:0] wdata;
    } reg_req_t;

    // Samples are counted, so the real time scales with the sample rate
    function automatic logic [HOLD_W-1:0] hold_samples(
        input logic [2:0] code);
        int us;
        case (code)
            3'h0: us = HOLD_US_0;
            3'h1: us = HOLD_US_1;
            3'h2: us = HOLD_US_2;
            3'h3: us = HOLD_US_3;
            3'h4: us = HOLD_US_4;
            3'h5: us = HOLD_US_5;
            3'h6: us = HOLD_US_6;
            default: us = HOLD_US_7;
        endcase
        return HOLD_W'(us * FS_REF_KHZ / 1000);
    endfunction

endpackage

// >>> logic/zero_run_detect.sv
// Counts consecutive zero samples on one channel against a hold code
module zero_run_detect #(
    parameter int SAMPLE_W = 24
) (
    input wire logic clk_sys_i,
    input wire logic sys_rst_i,
    input wire logic sample_valid_i,
    input wire logic [SAMPLE_W-1:0] sample_i,
    input wire logic [2:0] hold_code_i,
    output logic qualify_o
);
    import vramp_pkg::*;

    if (SAMPLE_W < 2 || SAMPLE_W > 32) begin : g_bad_width
        $error("zero_run_detect: SAMPLE_W must be 2..32");
    end

    logic [HOLD_W-1:0] run;
    wire logic [HOLD_W-1:0] limit = hold_samples(hold_code_i);
    wire logic is_zero = (sample_i == '0);
    wire logic at_limit = (run >= limit);

    // ==========================================================
    // Run counter: saturates at the limit so a long silence stays muted
    always_ff @(posedge clk_sys_i) begin
        if (sys_rst_i) begin
            run <= '0;
        end else if (sample_valid_i) begin
            if (!is_zero) begin
                run <= '0;
            end else if (!at_limit) begin
                run <= run + HOLD_W'(1);
            end
        end
    end

    // Limit may be lowered by software; compare keeps that immediate
    always_ff @(posedge clk_sys_i) begin
        if (sys_rst_i) begin
            qualify_o <= 1'b0;
        end else begin
            qualify_o <= (run >= limit);
        end
    end

    // ==========================================================
    // Assertions
    a_nonzero_clears: assert property (@(posedge clk_sys_i)
        disable iff (sys_rst_i)
        sample_valid_i && !is_zero |=> ##1 !qualify_o)
        else $error("nonzero sample did not release the zero run");

    a_run_counts_up: assert property (@(posedge clk_sys_i)
        disable iff (sys_rst_i)
        sample_valid_i && is_zero && !at_limit
        |=> run == $past(run) + HOLD_W'(1))
        else $error("zero run did not advance on a zero sample");

endmodule

// >>> dv/vramp_host.sv
// Host model that drives the control port of the volume/mute block
module vramp_host (
    input wire logic clk_sys_i,
    output vramp_pkg::reg_req_t reg_req_o,
    input wire logic [7:0] reg_rdata_i
);
    timeunit 1ns;
    timeprecision 1ns;
    import vramp_pkg::*;

    initial reg_req_o = '{wr: 1'b0, addr: 8'h00, wdata: 8'h00};

    // ==========================================================
    // Register cycles, launched just after falling edges
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk_sys_i);
        reg_req_o <= '{wr: 1'b1, addr: a, wdata: d};
        @(negedge clk_sys_i);
        // Stale data is inverted so a late sample cannot pass by luck
        reg_req_o <= '{wr: 1'b0, addr: a, wdata: ~d};
    endtask

    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(negedge clk_sys_i);
        reg_req_o.addr <= a;
        @(negedge clk_sys_i);
        d = reg_rdata_i;
    endtask

    // Bandwidth follows the switching frequency in use
    task automatic set_bw(input logic fast_switch);
        wr(STAGE_CFG_OFS, fast_switch ? 8'h60 : 8'h00);
    endtask
endmodule

// >>> dv/volume_ramp_automute_ctrl_bench.sv
// Self-checking bench of the volume ramp and auto mute block
module volume_ramp_automute_ctrl_bench;
    timeunit 1ns;
    timeprecision 1ns;
    import vramp_pkg::*;

    // Zero runs of hold codes 0 and 1 at the reference rate, in samples
    localparam int HOLD0 = 11500 * 96 / 1000;
    localparam int HOLD1 = 53000 * 96 / 1000;
    logic clk_sys_i = 1'b0;
    logic sys_rst_i = 1'b1;
    vramp_pkg::reg_req_t reg_req;
    logic [7:0] rdata, lvol, rvol;
    logic [7:0] level = VOL_UNITY;
    logic [7:0] ncfg = 8'hbc;
    audio_in_t audio_s = '0, audio_p = '0;
    logic cfault = 1'b0, sloss = 1'b0, stream = 1'b0;
    // Streamed and pulsed samples each keep a driver of their own
    wire audio_in_t audio = stream ? audio_s : audio_p;
    logic lmute, rmute, emerg, phase;
    logic [1:0] bw;
    logic [4:0] atten;
    logic [31:0] seed = 32'h638a;
    int failures = 0, n_checks = 0, cycles = 0;
    logic [7:0] ofs[5] = '{EMERG_RAMP_OFS, MUTE_EN_OFS, HOLD_TIME_OFS,
        STAGE_CFG_OFS, GAIN_TRIM_OFS};
    logic [7:0] rst_val[5] = '{8'h30, 8'h07, 8'h00, 8'h00, 8'h00};
    logic [1:0] rates[5] = '{2'h0, 2'h1, 2'h2, 2'h0, 2'h3};
    logic [1:0] steps[5] = '{2'h1, 2'h2, 2'h3, 2'h0, 2'h0};

    initial forever #25 clk_sys_i = ~clk_sys_i;

    volume_ramp_automute_ctrl #(.SAMPLE_W(24)) dut (
        .clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i),
        .reg_req_i(reg_req), .reg_rdata_o(rdata), .audio_i(audio),
        .digital_volume_level_i(level), .normal_ramp_cfg_i(ncfg),
        .clock_fault_i(cfault), .supply_loss_i(sloss),
        .left_volume_o(lvol), .right_volume_o(rvol),
        .left_auto_mute_o(lmute), .right_auto_mute_o(rmute),
        .emergency_active_o(emerg), .loop_bandwidth_o(bw),
        .pwm_in_phase_o(phase), .output_attenuation_o(atten));

    vramp_host host (.clk_sys_i(clk_sys_i), .reg_req_o(reg_req),
        .reg_rdata_i(rdata));

    // ==========================================================
    // Helpers
    function automatic logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction

    function automatic logic [23:0] nz();
        return 24'(xs()) | 24'h1;
    endfunction

    function automatic logic [7:0] step_len(input logic [1:0] s);
        return 8'h08 >> s;
    endfunction

    function automatic logic [7:0] period(input logic [1:0] r);
        return 8'h01 << r;
    endfunction

    task automatic check(input string what, input logic [7:0] got,
        input logic [7:0] exp);
        n_checks++;
        if (got !== exp) begin
            failures++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic finish_test();
        if (failures == 0 && n_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    task automatic do_reset();
        @(negedge clk_sys_i);
        sys_rst_i = 1'b1;
        repeat (8) @(negedge clk_sys_i);
        sys_rst_i = 1'b0;
    endtask

    // Samples go out on every second cycle or slower
    task automatic send(input int n, input logic lz, input logic rz,
        input int gap);
        repeat (n) begin
            @(negedge clk_sys_i);
            audio_p <= '{valid: 1'b1, left: lz ? 24'h0 : nz(),
                right: rz ? 24'h0 : nz()};
            @(negedge clk_sys_i);
            audio_p.valid <= 1'b0;
            repeat (gap) @(negedge clk_sys_i);
        end
    endtask

    task automatic mutes(input string w, input logic l, input logic r);
        repeat (4) @(negedge clk_sys_i);
        check({w, " left"}, {7'h0, lmute}, {7'h0, l});
        check({w, " right"}, {7'h0, rmute}, {7'h0, r});
    endtask

    always @(negedge clk_sys_i) begin
        if (stream) begin
            audio_s <= '{valid: 1'b1, left: nz(), right: nz()};
        end
    end

    // Hang guard, about twice the cycles the whole sequence needs
    always @(posedge clk_sys_i) begin
        cycles++;
        if (cycles == 40000) begin
            failures++;
            finish_test();
        end
    end

    // ==========================================================
    // Main sequence
    initial begin
        int cnt;
        logic [7:0] prev, v;
        do_reset();
        foreach (ofs[j]) begin
            host.rd(ofs[j], v);
            check("reset value", v, rst_val[j]);
        end
        check("reset volume", lvol, VOL_UNITY);
        foreach (ofs[j]) begin
            v = 8'(xs());
            host.wr(ofs[j], v);
            host.rd(ofs[j], prev);
            check("readback", prev, v);
            if (ofs[j] == STAGE_CFG_OFS) begin
                check("bandwidth", {6'h0, bw}, {6'h0, v[6:5]});
                check("phase", {7'h0, phase}, {7'h0, v[0]});
            end
        end
        check("atten", {3'h0, atten}, {3'h0, v[4:0]});
        host.wr(GAIN_TRIM_OFS, 8'h1f);
        check("atten max", {3'h0, atten}, 8'h1f);
        host.set_bw(1'b1);
        check("fast bandwidth", {6'h0, bw}, 8'h03);
        host.wr(STATUS_OFS, 8'hff);
        host.rd(STATUS_OFS, v);
        check("status write", v, 8'h00);
        host.wr(8'h60, 8'h5a);
        host.rd(8'h60, v);
        check("unmapped", v, 8'h00);
        do_reset();
        // Emergency ramp against a slow normal ramp-down
        stream = 1'b1;
        for (int i = 0; i < 5; i++) begin
            host.wr(EMERG_RAMP_OFS, {rates[i], steps[i], 4'h0});
            if (i % 2 == 1) sloss = 1'b1;
            else cfault = 1'b1;
            cnt = 0;
            do begin
                @(negedge clk_sys_i);
                cnt++;
            end while (lvol === VOL_UNITY && cnt < 40);
            if (rates[i] == RATE_INSTANT) begin
                check("instant mute", lvol, VOL_MUTE);
            end else begin
                for (int k = 0; k < 3; k++) begin
                    prev = lvol;
                    cnt = 0;
                    do begin
                        @(negedge clk_sys_i);
                        cnt++;
                    end while (lvol === prev && cnt < 10);
                    check("gap", 8'(cnt), period(rates[i]));
                    check("step", lvol, prev + step_len(steps[i]));
                end
            end
            check("emergency", {7'h0, emerg}, 8'h01);
            check("right follows", rvol, lvol);
            host.rd(STATUS_OFS, v);
            check("status emergency", v, 8'h04);
            cfault = 1'b0;
            sloss = 1'b0;
            repeat (20) @(negedge clk_sys_i);
            check("restore", lvol, level);
        end
        // Normal ramp-down toward a random volume target
        level = 8'h31 + (8'(xs()) & 8'h1f);
        repeat (140) @(negedge clk_sys_i);
        check("target reached", lvol, level);
        level = VOL_UNITY;
        @(negedge clk_sys_i);
        check("instant up", rvol, VOL_UNITY);
        stream = 1'b0;
        @(negedge clk_sys_i);
        // Auto mute on zero runs
        host.wr(MUTE_EN_OFS, 8'h03);
        send(HOLD0 - 1, 1'b1, 1'b0, 0);
        mutes("short run", 1'b0, 1'b0);
        send(1, 1'b1, 1'b0, 0);
        mutes("full run", 1'b1, 1'b0);
        host.wr(MUTE_EN_OFS, 8'h02);
        mutes("left disabled", 1'b0, 1'b0);
        host.wr(HOLD_TIME_OFS, 8'h10);
        host.wr(MUTE_EN_OFS, 8'h03);
        send(HOLD0, 1'b1, 1'b1, 2);
        mutes("split codes", 1'b0, 1'b1);
        host.rd(STATUS_OFS, v);
        check("status", v, 8'h02);
        send(HOLD1 - 2 * HOLD0 - 1, 1'b1, 1'b1, 0);
        mutes("left code 1 short", 1'b0, 1'b1);
        send(1, 1'b1, 1'b1, 0);
        mutes("left code 1", 1'b1, 1'b1);
        host.wr(MUTE_EN_OFS, 8'h07);
        host.wr(HOLD_TIME_OFS, 8'h00);
        send(1, 1'b0, 1'b0, 0);
        mutes("release", 1'b0, 1'b0);
        send(HOLD0, 1'b1, 1'b0, 0);
        mutes("joint one", 1'b0, 1'b0);
        send(HOLD0, 1'b1, 1'b1, 0);
        mutes("joint both", 1'b1, 1'b1);
        send(1, 1'b1, 1'b0, 0);
        mutes("joint release", 1'b0, 1'b0);
        finish_test();
    end
endmodule
